//--- core/sbhp_pkg.sv
// Purpose: constants for the shared bus host port
// Assumes: 20 MHz ref_clk; strobes and select come from the host asynchronously
// Notes: How it works list below
// How it works
// - command low, 16-bit mode: data moves on all sixteen shared lines.
// - command low, 8-bit mode: data moves on lower eight lines only.
// - command high, 16-bit mode: address bits 7..2 sit on lines 7..2.
// - 16-bit address phase: byte enables on lines 15..12; lines 11..8 ignored.
// - command high, 8-bit mode: full eight-bit address on lines 7..0.
// - command select chooses data access (low) or address access (high).
// - device answers bus accesses only while device select is low.
// - device drives eeprom select while it accesses the external memory.
// - width strap level is latched at reset release; picks 16 or 8 bits.
package sbhp_pkg;
    localparam int          BUS_W       = 16;
    localparam int          NARROW_W    = 8;
    localparam int          ADDR_W      = 8;
    localparam int          BE_W        = 4;
    localparam int          BE_LSB      = 12;
    localparam int          ADDR_LSB16  = 2;
    localparam int          SYNC_W      = 3;
    localparam int          CLK_HZ      = 20_000_000;
    localparam int          RESET_MS    = 10;
    localparam int          RESET_CYC   = (CLK_HZ / 1000) * RESET_MS;
    localparam logic [7:0]  ADDR_RST    = 8'h00;
    localparam logic [3:0]  BE_RST      = 4'h0;
    localparam logic [15:0] DATA_RST    = 16'h0000;
    localparam logic        WIDE_RST    = 1'b1;

    typedef enum logic [1:0] {
        SBHP_IDLE  = 2'b00,
        SBHP_READ  = 2'b01,
        SBHP_WRITE = 2'b10
    } sbhp_state_type;
endpackage : sbhp_pkg

//--- core/sbhp_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to clk
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sbhp_sync #(
    parameter int          W   = 1,
    parameter logic [15:0] RST = 16'h0000
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] agree;

    // stage one is read only by stage two
    assign agree = ~(s2_q ^ s3_q);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_q <= RST[W-1:0];
            s2_q <= RST[W-1:0];
            s3_q <= RST[W-1:0];
            q    <= RST[W-1:0];
        end
        else
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q    <= (agree & s3_q) | (~agree & q);
        end
    end
endmodule : sbhp_sync
`default_nettype wire

//--- core/sbhp_port.sv
// Purpose: device side of the shared parallel host bus
// Assumes: host keeps hw_reset_n low long enough; strobes are asynchronous
// Notes: user side sees address, byte enables, write data and read data
`timescale 1ns/1ps
`default_nettype none
module sbhp_port
    import sbhp_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        hw_reset_n,
    input  wire logic        width_strap_pin,
    input  wire logic        device_select_n,
    input  wire logic        cmd_select,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic [15:0] shared_bus_lines_in,
    output var  logic [15:0] shared_bus_lines_out,
    output var  logic [15:0] shared_bus_lines_oe,
    input  wire logic        eeprom_busy,
    output var  logic        eeprom_select,
    output var  logic        bus_wide,
    output var  logic [7:0]  reg_addr,
    output var  logic [3:0]  byte_lane_enables,
    output var  logic        addr_strobe,
    output var  logic        wr_strobe,
    output var  logic [15:0] wr_data,
    output var  logic        rd_strobe,
    input  wire logic [15:0] rd_data
);
    logic           sel_n_s;
    logic           cmd_s;
    logic           rd_n_s;
    logic           wr_n_s;
    logic           hwr_n_s;
    logic           strap_s;
    logic [15:0]    bus_s;
    logic           rst_seen_q;
    logic           bus_wide_q;
    sbhp_state_type state_q;
    sbhp_state_type state_d;
    logic [15:0]    rd_hold_q;

    wire  logic     rst_n       = arst_n & hwr_n_s;
    wire  logic     selected    = ~sel_n_s;
    wire  logic     rd_act      = selected & ~rd_n_s;
    wire  logic     wr_act      = selected & ~wr_n_s;
    wire  logic     is_addr     = cmd_s;
    wire  logic     start_rd    = (state_q == SBHP_IDLE) & rd_act & ~is_addr;
    wire  logic     start_wr    = (state_q == SBHP_IDLE) & wr_act;
    // 16-bit address phase: A[7:2] and enables; lines 11..8 never looked at
    wire  logic [7:0] addr16    = {bus_s[7:ADDR_LSB16], 2'b00};
    wire  logic [3:0] be16      = bus_s[BE_LSB +: BE_W];
    wire  logic [7:0] addr8     = bus_s[ADDR_W-1:0];
    wire  logic [15:0] wdata    = bus_wide_q ? bus_s
                                  : {8'h00, bus_s[NARROW_W-1:0]};
    wire  logic [15:0] drive_oe = bus_wide_q ? 16'hFFFF : 16'h00FF;

    sbhp_sync #(.W(1), .RST(16'h0001)) u_sel   (.clk(ref_clk), .arst_n(arst_n),
        .d(device_select_n), .q(sel_n_s));
    sbhp_sync #(.W(1), .RST(16'h0000)) u_cmd   (.clk(ref_clk), .arst_n(arst_n),
        .d(cmd_select), .q(cmd_s));
    sbhp_sync #(.W(1), .RST(16'h0001)) u_rd    (.clk(ref_clk), .arst_n(arst_n),
        .d(read_strobe_n), .q(rd_n_s));
    sbhp_sync #(.W(1), .RST(16'h0001)) u_wr    (.clk(ref_clk), .arst_n(arst_n),
        .d(write_strobe_n), .q(wr_n_s));
    sbhp_sync #(.W(1), .RST(16'h0000)) u_hwr   (.clk(ref_clk), .arst_n(arst_n),
        .d(hw_reset_n), .q(hwr_n_s));
    sbhp_sync #(.W(1), .RST(16'h0001)) u_strap (.clk(ref_clk), .arst_n(arst_n),
        .d(width_strap_pin), .q(strap_s));
    sbhp_sync #(.W(16), .RST(16'h0000)) u_bus  (.clk(ref_clk), .arst_n(arst_n),
        .d(shared_bus_lines_in), .q(bus_s));

    // strap captured on the first clock after reset release, never under reset
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_seen_q <= 1'b0;
            bus_wide_q <= WIDE_RST;
        end
        else if (!rst_seen_q)
        begin
            rst_seen_q <= 1'b1;
            bus_wide_q <= strap_s;
        end
    end

    // a strobe is one access; wait for its release before the next one
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SBHP_IDLE:
            begin
                if (start_rd)
                    state_d = SBHP_READ;
                else if (start_wr)
                    state_d = SBHP_WRITE;
            end
            SBHP_READ:
            begin
                if (!rd_act)
                    state_d = SBHP_IDLE;
            end
            SBHP_WRITE:
            begin
                if (!wr_act)
                    state_d = SBHP_IDLE;
            end
            default:
                state_d = SBHP_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= SBHP_IDLE;
        else
            state_q <= state_d;
    end

    // one-cycle pulses and the words they qualify, decoded once here
    wire  logic        take_addr = start_wr & is_addr;
    wire  logic        take_data = start_wr & ~is_addr;
    wire  logic [7:0]  addr_next = bus_wide_q ? addr16 : addr8;
    wire  logic [3:0]  be_next   = bus_wide_q ? be16 : BE_RST;
    wire  logic [15:0] rd_word   = bus_wide_q ? rd_data
                                   : {8'h00, rd_data[NARROW_W-1:0]};
    // drive only in a read, after the word has been taken from the user side;
    // the gap cycle keeps stale hold data off the pins
    wire  logic        drive_now = (state_q == SBHP_READ) & rd_act & ~rd_strobe;
    wire  logic [15:0] oe_next   = drive_now ? drive_oe : 16'h0000;

    // strobes are pulses: they never stretch, even if the host holds its strobe
    // a held strobe still gives a single pulse; the state machine waits for release
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_strobe <= 1'b0;
            wr_strobe   <= 1'b0;
            rd_strobe   <= 1'b0;
        end
        else
        begin
            addr_strobe <= take_addr;
            wr_strobe   <= take_data;
            rd_strobe   <= start_rd;
        end
    end

    // address and enables change together, at the edge that raises addr_strobe
    // in 8-bit mode the enables read as zero: the whole address is on the low lines
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_addr          <= ADDR_RST;
            byte_lane_enables <= BE_RST;
        end
        else if (take_addr)
        begin
            reg_addr          <= addr_next;
            byte_lane_enables <= be_next;
        end
    end

    // write word stands until the next data write, so the user may take it late
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            wr_data <= DATA_RST;
        else if (take_data)
            wr_data <= wdata;
    end

    // read data is taken one cycle after rd_strobe, held for the whole strobe
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_hold_q <= DATA_RST;
        else if (rd_strobe)
            rd_hold_q <= rd_word;
    end

    // pin side: data and enables both registered so they switch on one edge
    // the pull-downs hold the lines low whenever these enables are clear and the host drives nothing
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shared_bus_lines_out <= DATA_RST;
            shared_bus_lines_oe  <= 16'h0000;
        end
        else
        begin
            shared_bus_lines_out <= rd_hold_q;
            shared_bus_lines_oe  <= oe_next;
        end
    end

    // eeprom select follows the user's busy level one cycle late
    // only a registered copy; the eeprom sequencer lives outside the port
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            eeprom_select <= 1'b0;
        else
            eeprom_select <= eeprom_busy;
    end

    // width mode as seen by the user side; stays at its reset value until latched
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            bus_wide <= WIDE_RST;
        else
            bus_wide <= bus_wide_q;
    end
endmodule : sbhp_port
`default_nettype wire

//--- verif/sbhp_port_asserts.sv
// Purpose: port checks for sbhp_port
// Assumes: one clock domain
// Notes: either reset disables the checks
`timescale 1ns/1ps
`default_nettype none
module sbhp_port_asserts (
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic        hw_reset_n,
    input wire logic        device_select_n,
    input wire logic        eeprom_busy,
    input wire logic        eeprom_select,
    input wire logic [15:0] shared_bus_lines_oe,
    input wire logic        bus_wide,
    input wire logic [7:0]  reg_addr,
    input wire logic [3:0]  byte_lane_enables,
    input wire logic        addr_strobe,
    input wire logic        wr_strobe,
    input wire logic        rd_strobe
);
    wire logic        any_stb = addr_strobe | wr_strobe | rd_strobe;
    wire logic [15:0] oe      = shared_bus_lines_oe;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n || !hw_reset_n);
    a_wide_lanes: assert property (oe != 16'h0000 && bus_wide |-> oe == 16'hFFFF)
        else $error("wide read not on all lines");
    a_narrow_oe: assert property (!bus_wide |-> oe[15:8] == 8'h00)
        else $error("narrow mode drives upper lines");
    a_wide_addr: assert property (addr_strobe && bus_wide |-> reg_addr[1:0] == 2'b00)
        else $error("wide address low bits set");
    a_narrow_be: assert property (addr_strobe && !bus_wide |-> byte_lane_enables == 4'h0)
        else $error("narrow address has byte enables");
    a_one_strobe: assert property (any_stb |=> !any_stb)
        else $error("strobe longer than one cycle");
    a_desel_quiet: assert property (device_select_n [*8] |-> !any_stb && oe == 16'h0000)
        else $error("deselected port active");
    a_eeprom_sel: assert property ($rose(eeprom_busy) |=> eeprom_select)
        else $error("eeprom select missing");
    a_read_drive: assert property (rd_strobe |-> ##2 oe != 16'h0000)
        else $error("read data not driven");
    cover property (addr_strobe && bus_wide);
    cover property (addr_strobe && !bus_wide);
    cover property (rd_strobe ##2 oe != 16'h0000);
endmodule : sbhp_port_asserts
bind sbhp_port sbhp_port_asserts u_chk (.ref_clk, .arst_n, .hw_reset_n, .device_select_n,
    .eeprom_busy, .eeprom_select, .shared_bus_lines_oe, .bus_wide, .reg_addr,
    .byte_lane_enables, .addr_strobe, .wr_strobe, .rd_strobe);
`default_nettype wire

//--- verif/sbhp_host.sv
// Purpose: host cpu model for the shared bus
// Assumes: lines have pull-downs
// Notes: fixed strobe lengths, no ready signal
`timescale 1ns/1ps
`default_nettype none
module sbhp_host #(
    parameter int HOLD = 8
) (
    input  wire logic        clk,
    input  wire logic [15:0] lines_out,
    input  wire logic [15:0] lines_oe,
    output var  logic        sel_n,
    output var  logic        cmd,
    output var  logic        rd_n,
    output var  logic        wr_n,
    output var  logic        hw_rst_n,
    output wire logic [15:0] lines_in
);
    logic        drv;
    logic [15:0] dq;
    // released lines fall to the pull-down level
    assign lines_in = (lines_oe & lines_out) | (~lines_oe & (drv ? dq : 16'h0000));
    initial
    begin
        {sel_n, cmd, rd_n, wr_n, hw_rst_n, drv} = 6'b101110;
        dq = 16'h0000;
    end
    // hold far shorter than the real supply wait to keep runs short
    task pin_reset;
        @(posedge clk);
        hw_rst_n <= 1'b0;
        repeat (HOLD) @(posedge clk);
        hw_rst_n <= 1'b1;
    endtask : pin_reset
    task xfer(input logic sel, input logic c, input logic w, input logic [15:0] d,
              output logic [15:0] q);
        @(posedge clk);
        sel_n <= ~sel;
        cmd <= c;
        drv <= w;
        dq <= d;
        @(posedge clk);
        if (w) wr_n <= 1'b0;
        else rd_n <= 1'b0;
        repeat (12) @(posedge clk);
        @(negedge clk) q = lines_in;
        @(posedge clk);
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (8) @(posedge clk);
        sel_n <= 1'b1;
        drv <= 1'b0;
    endtask : xfer
endmodule : sbhp_host
`default_nettype wire

//--- verif/shared_bus_host_port_test.sv
// Purpose: self-checking bench for sbhp_port
// Assumes: host model drives the pins
// Notes: both strap widths are exercised
`timescale 1ns/1ps
`default_nettype none
module shared_bus_host_port_test;
    import sbhp_pkg::*;
    logic        ref_clk, arst_n, hw_reset_n, width_strap_pin, device_select_n, cmd_select;
    logic        read_strobe_n, write_strobe_n, eeprom_busy, eeprom_select, bus_wide;
    logic        addr_strobe, wr_strobe, rd_strobe;
    logic [15:0] shared_bus_lines_in, shared_bus_lines_out, shared_bus_lines_oe;
    logic [15:0] wr_data, rd_data, q;
    logic [7:0]  reg_addr;
    logic [3:0]  byte_lane_enables;
    int          n_errors = 0, checks = 0, n_acc = 0;
    sbhp_port dut (.ref_clk, .arst_n, .hw_reset_n, .width_strap_pin, .device_select_n,
        .cmd_select, .read_strobe_n, .write_strobe_n, .shared_bus_lines_in, .shared_bus_lines_out,
        .shared_bus_lines_oe, .eeprom_busy, .eeprom_select, .bus_wide, .reg_addr,
        .byte_lane_enables, .addr_strobe, .wr_strobe, .wr_data, .rd_strobe, .rd_data);
    sbhp_host host (.clk(ref_clk), .lines_out(shared_bus_lines_out),
        .lines_oe(shared_bus_lines_oe), .sel_n(device_select_n), .cmd(cmd_select),
        .rd_n(read_strobe_n), .wr_n(write_strobe_n), .hw_rst_n(hw_reset_n),
        .lines_in(shared_bus_lines_in));
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) n_acc += addr_strobe + wr_strobe + rd_strobe;
    task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task results;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    task boot(input logic s);
        width_strap_pin <= s;
        host.pin_reset();
        repeat (8) @(posedge ref_clk);
        chk("bus_wide", {15'h0, bus_wide}, {15'h0, s});
    endtask : boot
    task t_wide;
        int n0;
        boot(1'b1);
        n0 = n_acc;
        host.xfer(1'b1, 1'b1, 1'b1, 16'hA5F7, q); // lines 11:8 must be ignored
        chk("reg_addr", {8'h00, reg_addr}, 16'h00F4);
        chk("byte_lane_enables", {12'h000, byte_lane_enables}, 16'h000A);
        host.xfer(1'b1, 1'b0, 1'b1, 16'h1234, q);
        chk("wr_data", wr_data, 16'h1234);
        rd_data <= 16'hBEEF;
        host.xfer(1'b1, 1'b0, 1'b0, 16'h0000, q);
        chk("read", q, 16'hBEEF);
        chk("accesses", 16'(n_acc - n0), 16'h0003);
        $display("test wide done");
    endtask : t_wide
    task t_narrow;
        boot(1'b0);
        host.xfer(1'b1, 1'b1, 1'b1, 16'h00F7, q);
        chk("reg_addr", {8'h00, reg_addr}, 16'h00F7);
        chk("byte_lane_enables", {12'h000, byte_lane_enables}, 16'h0000);
        host.xfer(1'b1, 1'b0, 1'b1, 16'h0055, q);
        chk("wr_data", wr_data, 16'h0055);
        host.xfer(1'b1, 1'b0, 1'b0, 16'h0000, q);
        chk("read", q, 16'h00EF);
        $display("test narrow done");
    endtask : t_narrow
    task t_misc;
        int n0;
        n0 = n_acc;
        host.xfer(1'b0, 1'b0, 1'b0, 16'h0000, q);
        chk("deselected read", q, 16'h0000);
        chk("accesses", 16'(n_acc - n0), 16'h0000);
        n0 = n_acc;
        host.xfer(1'b1, 1'b1, 1'b0, 16'h0000, q);
        chk("address read", q, 16'h0000);
        chk("accesses", 16'(n_acc - n0), 16'h0000);
        eeprom_busy <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("eeprom_select", {15'h0, eeprom_select}, 16'h0001);
        eeprom_busy <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("eeprom_select", {15'h0, eeprom_select}, 16'h0000);
        $display("test misc done");
    endtask : t_misc
    initial
    begin
        arst_n = 1'b0;
        width_strap_pin = 1'b1;
        eeprom_busy = 1'b0;
        rd_data = 16'h0000;
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_wide();
        t_narrow();
        t_misc();
        results();
    end
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        results();
    end
endmodule : shared_bus_host_port_test
`default_nettype wire
